/* core/scs_regs.svh */
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
// Function
// RULE_01: The erase command erases every group chosen by the earlier tag-start and tag-end commands.
// RULE_02: The lock command ignores its 32-bit argument, gets the busy-extended answer and hands a password or lock data block to the back end.
// RULE_03: The lock data block is as long as the block length the host set before.
// RULE_04: The operating-conditions read takes no argument and is answered with the five-byte operating-conditions answer.
// RULE_05: The CRC toggle command looks only at argument bit 0, one enables and zero disables CRC checking, answered with the one-byte status.
// RULE_06: Until the host sets a block length the card uses the default length from its card-specific data register.
// RULE_07: A read or write transfer may not cross a physical block boundary unless the misalign flag for its direction is set.
// RULE_08: The busy-extended answer is the one-byte status followed by an optional busy indication.
// RULE_09: The write-protect status payload is 32 protection bits for 32 groups from the given address, then 16 CRC bits.
// RULE_10: In that payload the last, least significant protection bit belongs to the first addressed group.
// RULE_11: Protection bits of groups past the valid address range are sent as zero.
// RULE_12: The one-byte status always has its top bit clear and every other bit is a flag that reads one when set.
// RULE_13: While busy the card sends zero bytes and the host waits for a non-zero byte before its next command.
// RULE_14: The operating-conditions answer is five bytes, the status byte first and then the four register bytes.
// RULE_15: Reserved or unsupported commands are not executed and are flagged illegal in the status byte.

`define SCS_CMD_SET_BLKLEN 6'h10
`define SCS_CMD_READ_BLOCK 6'h11
`define SCS_CMD_WRITE_BLOCK 6'h18
`define SCS_CMD_WP_STATUS 6'h1e
`define SCS_CMD_TAG_START 6'h23
`define SCS_CMD_TAG_END 6'h24
`define SCS_CMD_ERASE 6'h26
`define SCS_CMD_LOCK 6'h2a
`define SCS_CMD_READ_OPC 6'h3a
`define SCS_CMD_CRC_ONOFF 6'h3b

`define SCS_MAX_BLK_LEN 12'h800
`define SCS_START_TOKEN 8'hfe
`define SCS_BUSY_BYTE 8'h00
`define SCS_CRC16_POLY 16'h1021
`define SCS_OPC_LEFT 3'h3
`define SCS_WP_LEFT 3'h6

`define SCS_REG_IRQ_STATUS 8'h00
`define SCS_REG_IRQ_MASK 8'h04
`define SCS_REG_DEF_CFG 8'h08
`define SCS_REG_OPC 8'h0c
`define SCS_REG_WP_LAST 8'h10
`define SCS_REG_STATE 8'h14

`define SCS_RST_DEF_LEN 12'h200
`define SCS_RST_OPC 32'h00ff_8000
`define SCS_RST_WP_LAST 32'hffff_ffff

`define SCS_IRQ_DONE 0
`define SCS_IRQ_ILLEGAL 1
`define SCS_IRQ_CRC 2
`define SCS_IRQ_ERASE 3
`define SCS_CFG_RD_MIS 12
`define SCS_CFG_WR_MIS 13
`endif

/* core/scs_pkg.sv */
package scs_pkg;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_ST = 4'b0010,
      S_BUSY = 4'b0100,
      S_DATA = 4'b1000
   } scs_state_e;

   typedef enum logic [1:0] {
      K_PLAIN = 2'h0,
      K_BUSY = 2'h1,
      K_OPC = 2'h2,
      K_WP = 2'h3
   } scs_kind_e;

   typedef logic [11:0] scs_len_t;
endpackage : scs_pkg

/* core/scs_wp_if.sv */
`timescale 1ns/10ps
interface scs_wp_if;
   logic [31:0] raw_bits;
   logic [31:0] first_group;
   logic [31:0] last_group;
   logic [31:0] masked;
   logic [15:0] crc;
   modport master (
      output raw_bits,
      output first_group,
      output last_group,
      input masked,
      input crc
   );
   modport builder (
      input raw_bits,
      input first_group,
      input last_group,
      output masked,
      output crc
   );
endinterface : scs_wp_if

/* core/scs_wp_payload.sv */
`timescale 1ns/10ps
`include "scs_regs.svh"
module scs_wp_payload (
   scs_wp_if.builder wp
);
   logic [32:0] grp;
   logic [31:0] bits;
   logic [15:0] crc;
   logic fb;

   always_comb begin
      grp = 33'h0_0000_0000;
      bits = 32'h0000_0000;
      crc = 16'h0000;
      fb = 1'b0;
      for (int i = 0; i < 32; i++) begin
         grp = {1'b0, wp.first_group} + 33'(i);
         // bit i is group first+i, so bit 0 goes out last
         if (!grp[32] && grp[31:0] <= wp.last_group) begin // RULE_10
            bits[i] = wp.raw_bits[i];
         end // RULE_11
      end
      // crc over the 32 bits in wire order, msb first
      for (int i = 31; i >= 0; i--) begin
         fb = crc[15] ^ bits[i];
         crc = {crc[14:0], 1'b0} ^ (fb ? `SCS_CRC16_POLY : 16'h0000); // RULE_09
      end
      wp.masked = bits;
      wp.crc = crc;
   end
endmodule : scs_wp_payload

/* core/scs_cmd_core.sv */
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "scs_regs.svh"
module scs_cmd_core #(
   parameter int PHYS_BLK_BITS = 9,
   parameter int WP_SHIFT = 9
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic [5:0] cmd_index_i,
   input wire logic [31:0] cmd_arg_i,
   input wire logic cmd_crc_err_i,
   input wire logic card_idle_i,
   input wire logic backend_busy_i,
   input wire logic [31:0] wp_bits_i,
   input wire logic rsp_ready_i,
   output logic rsp_valid_o,
   output logic [7:0] rsp_byte_o,
   output logic crc_check_en_o,
   output logic erase_start_o,
   output logic [31:0] erase_first_o,
   output logic [31:0] erase_last_o,
   output logic lock_start_o,
   output logic xfer_start_o,
   output logic xfer_write_o,
   output logic [31:0] xfer_addr_o,
   output logic [11:0] data_len_o,
   output logic [31:0] wp_first_o,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o
);
   if (PHYS_BLK_BITS < 1 || PHYS_BLK_BITS > 11) begin : g_bad_blk
      $error("PHYS_BLK_BITS out of range");
   end
   if (WP_SHIFT < 0 || WP_SHIFT > 31) begin : g_bad_wp
      $error("WP_SHIFT out of range");
   end

   scs_pkg::scs_state_e state, next_state;
   scs_pkg::scs_kind_e kind, next_kind;
   logic [7:0] rsp_byte, next_rsp_byte;
   logic [55:0] tx_shift, next_tx_shift;
   logic [2:0] tx_left, next_tx_left;
   logic crc_en, next_crc_en;
   scs_pkg::scs_len_t blk_len, next_blk_len;
   logic blk_set, next_blk_set;
   logic tag_s, next_tag_s;
   logic tag_e, next_tag_e;
   logic [31:0] erase_first, next_erase_first;
   logic [31:0] erase_last, next_erase_last;
   logic [31:0] wp_first, next_wp_first;
   logic erase_start, next_erase_start;
   logic lock_start, next_lock_start;
   logic xfer_start, next_xfer_start;
   logic xfer_write, next_xfer_write;
   logic [31:0] xfer_addr, next_xfer_addr;
   scs_pkg::scs_len_t data_len, next_data_len;
   logic [3:0] irq_status, next_irq_status;
   logic [3:0] irq_mask, next_irq_mask;
   scs_pkg::scs_len_t def_len, next_def_len;
   logic rd_mis, next_rd_mis;
   logic wr_mis, next_wr_mis;
   logic [31:0] opc, next_opc;
   logic [31:0] wp_last, next_wp_last;
   logic [31:0] reg_rdata, next_reg_rdata;

   logic accept, fire, mis_ok;
   logic f_ill, f_crc, f_eseq, f_eres, f_adr, f_par;
   logic [12:0] xfer_end;
   logic [3:0] events;
   scs_pkg::scs_len_t eff_len;

   scs_wp_if wp ();
   assign wp.raw_bits = wp_bits_i;
   assign wp.first_group = wp_first;
   assign wp.last_group = wp_last;

   scs_wp_payload u_wp (
      .wp(wp)
   );

   // host-set length wins, else the card default
   assign eff_len = blk_set ? blk_len : def_len; // RULE_06
   assign accept = cmd_valid_i && (state == scs_pkg::S_IDLE);
   assign rsp_valid_o = (state == scs_pkg::S_ST) ||
                        (state == scs_pkg::S_DATA) ||
                        ((state == scs_pkg::S_BUSY) && backend_busy_i);
   assign fire = rsp_valid_o && rsp_ready_i;
   assign xfer_end = 13'(cmd_arg_i[PHYS_BLK_BITS-1:0]) + {1'b0, eff_len};

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_rsp_byte = rsp_byte;
      next_tx_shift = tx_shift;
      next_tx_left = tx_left;
      next_crc_en = crc_en;
      next_blk_len = blk_len;
      next_blk_set = blk_set;
      next_tag_s = tag_s;
      next_tag_e = tag_e;
      next_erase_first = erase_first;
      next_erase_last = erase_last;
      next_wp_first = wp_first;
      next_erase_start = 1'b0;
      next_lock_start = 1'b0;
      next_xfer_start = 1'b0;
      next_xfer_write = xfer_write;
      next_xfer_addr = xfer_addr;
      next_data_len = data_len;
      next_irq_mask = irq_mask;
      next_def_len = def_len;
      next_rd_mis = rd_mis;
      next_wr_mis = wr_mis;
      next_opc = opc;
      next_wp_last = wp_last;
      next_reg_rdata = 32'h0000_0000;
      f_ill = 1'b0;
      f_crc = 1'b0;
      f_eseq = 1'b0;
      f_eres = 1'b0;
      f_adr = 1'b0;
      f_par = 1'b0;
      mis_ok = 1'b0;

      if (accept) begin
         next_kind = scs_pkg::K_PLAIN;
         if (crc_en && cmd_crc_err_i) begin
            f_crc = 1'b1;
         end else begin
            // any other command breaks a pending erase sequence
            if (tag_s && cmd_index_i != `SCS_CMD_TAG_START &&
                cmd_index_i != `SCS_CMD_TAG_END &&
                cmd_index_i != `SCS_CMD_ERASE) begin
               f_eres = 1'b1;
               next_tag_s = 1'b0;
               next_tag_e = 1'b0;
            end
            case (cmd_index_i)
               `SCS_CMD_SET_BLKLEN: begin
                  if (cmd_arg_i == 32'h0000_0000 ||
                      cmd_arg_i > 32'(`SCS_MAX_BLK_LEN)) begin
                     f_par = 1'b1;
                  end else begin
                     next_blk_len = cmd_arg_i[11:0];
                     next_blk_set = 1'b1;
                  end
               end
               `SCS_CMD_READ_BLOCK, `SCS_CMD_WRITE_BLOCK: begin
                  mis_ok = (cmd_index_i == `SCS_CMD_WRITE_BLOCK) ?
                           wr_mis : rd_mis;
                  if (!mis_ok &&
                      xfer_end > 13'(1 << PHYS_BLK_BITS)) begin
                     f_adr = 1'b1; // RULE_07
                  end else begin
                     next_xfer_start = 1'b1;
                     next_xfer_write = (cmd_index_i == `SCS_CMD_WRITE_BLOCK);
                     next_xfer_addr = cmd_arg_i;
                     next_data_len = eff_len;
                  end
               end
               `SCS_CMD_WP_STATUS: begin
                  next_wp_first = cmd_arg_i >> WP_SHIFT;
                  next_kind = scs_pkg::K_WP; // RULE_09
               end
               `SCS_CMD_TAG_START: begin
                  next_tag_s = 1'b1;
                  next_tag_e = 1'b0;
                  next_erase_first = cmd_arg_i;
               end
               `SCS_CMD_TAG_END: begin
                  if (!tag_s) begin
                     f_eseq = 1'b1;
                  end else begin
                     next_tag_e = 1'b1;
                     next_erase_last = cmd_arg_i;
                  end
               end
               `SCS_CMD_ERASE: begin
                  if (!(tag_s && tag_e)) begin
                     f_eseq = 1'b1;
                  end else begin
                     next_erase_start = 1'b1; // RULE_01
                     next_kind = scs_pkg::K_BUSY;
                  end
                  next_tag_s = 1'b0;
                  next_tag_e = 1'b0;
               end
               `SCS_CMD_LOCK: begin
                  // argument is stuff bits and is not looked at
                  next_lock_start = 1'b1; // RULE_02
                  next_data_len = eff_len; // RULE_03
                  next_kind = scs_pkg::K_BUSY;
               end
               `SCS_CMD_READ_OPC: begin
                  next_kind = scs_pkg::K_OPC; // RULE_04
               end
               `SCS_CMD_CRC_ONOFF: begin
                  next_crc_en = cmd_arg_i[0]; // RULE_05
               end
               default: begin
                  f_ill = 1'b1; // RULE_15
               end
            endcase
         end
         // flags are fresh per command, so reading clears them
         next_rsp_byte = {1'b0, f_par, f_adr, f_eseq, f_crc, f_ill,
                          f_eres, card_idle_i}; // RULE_12
         next_state = scs_pkg::S_ST;
      end

      unique case (state)
         scs_pkg::S_IDLE: begin
         end
         scs_pkg::S_ST: begin
            if (fire) begin
               unique case (kind)
                  scs_pkg::K_PLAIN: next_state = scs_pkg::S_IDLE;
                  scs_pkg::K_BUSY: begin
                     next_rsp_byte = `SCS_BUSY_BYTE; // RULE_08
                     next_state = scs_pkg::S_BUSY;
                  end
                  scs_pkg::K_OPC: begin
                     next_rsp_byte = opc[31:24]; // RULE_14
                     next_tx_shift = {opc[23:0], 32'h0000_0000};
                     next_tx_left = `SCS_OPC_LEFT;
                     next_state = scs_pkg::S_DATA;
                  end
                  scs_pkg::K_WP: begin
                     next_rsp_byte = `SCS_START_TOKEN;
                     next_tx_shift = {wp.masked, wp.crc, 8'h00}; // RULE_09
                     next_tx_left = `SCS_WP_LEFT;
                     next_state = scs_pkg::S_DATA;
                  end
               endcase
            end
         end
         scs_pkg::S_BUSY: begin
            // zero bytes only while the back end holds busy
            if (!backend_busy_i) begin
               next_state = scs_pkg::S_IDLE; // RULE_13
            end
         end
         scs_pkg::S_DATA: begin
            if (fire) begin
               if (tx_left == 3'h0) begin
                  next_state = scs_pkg::S_IDLE;
               end else begin
                  next_rsp_byte = tx_shift[55:48];
                  next_tx_shift = {tx_shift[47:0], 8'h00};
                  next_tx_left = tx_left - 3'h1;
               end
            end
         end
      endcase

      events = 4'h0;
      events[`SCS_IRQ_DONE] = fire && (state == scs_pkg::S_ST);
      events[`SCS_IRQ_ILLEGAL] = f_ill;
      events[`SCS_IRQ_CRC] = f_crc;
      events[`SCS_IRQ_ERASE] = next_erase_start;
      // set beats a same-cycle write-one clear
      next_irq_status = irq_status | events;
      if (reg_wr_i && reg_addr_i == `SCS_REG_IRQ_STATUS) begin
         next_irq_status = (irq_status & ~reg_wdata_i[3:0]) | events;
      end
      if (reg_wr_i) begin
         case (reg_addr_i)
            `SCS_REG_IRQ_MASK: next_irq_mask = reg_wdata_i[3:0];
            `SCS_REG_DEF_CFG: begin
               next_def_len = reg_wdata_i[11:0];
               next_rd_mis = reg_wdata_i[`SCS_CFG_RD_MIS];
               next_wr_mis = reg_wdata_i[`SCS_CFG_WR_MIS];
            end
            `SCS_REG_OPC: next_opc = reg_wdata_i;
            `SCS_REG_WP_LAST: next_wp_last = reg_wdata_i;
            default: begin
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `SCS_REG_IRQ_STATUS: next_reg_rdata = {28'h000_0000, irq_status};
            `SCS_REG_IRQ_MASK: next_reg_rdata = {28'h000_0000, irq_mask};
            `SCS_REG_DEF_CFG: next_reg_rdata = {18'h0_0000, wr_mis, rd_mis,
                                               def_len};
            `SCS_REG_OPC: next_reg_rdata = opc;
            `SCS_REG_WP_LAST: next_reg_rdata = wp_last;
            `SCS_REG_STATE: next_reg_rdata = {12'h000, state, tag_e, tag_s,
                                             blk_set, crc_en, eff_len};
            default: next_reg_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= scs_pkg::S_IDLE;
         kind <= scs_pkg::K_PLAIN;
         rsp_byte <= 8'hff;
         tx_shift <= 56'h00_0000_0000_0000;
         tx_left <= 3'h0;
         crc_en <= 1'b0;
         blk_len <= `SCS_RST_DEF_LEN;
         blk_set <= 1'b0;
         tag_s <= 1'b0;
         tag_e <= 1'b0;
         erase_first <= 32'h0000_0000;
         erase_last <= 32'h0000_0000;
         wp_first <= 32'h0000_0000;
         erase_start <= 1'b0;
         lock_start <= 1'b0;
         xfer_start <= 1'b0;
         xfer_write <= 1'b0;
         xfer_addr <= 32'h0000_0000;
         data_len <= `SCS_RST_DEF_LEN;
         irq_status <= 4'h0;
         irq_mask <= 4'h0;
         def_len <= `SCS_RST_DEF_LEN;
         rd_mis <= 1'b0;
         wr_mis <= 1'b0;
         opc <= `SCS_RST_OPC;
         wp_last <= `SCS_RST_WP_LAST;
         reg_rdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
         kind <= next_kind;
         rsp_byte <= next_rsp_byte;
         tx_shift <= next_tx_shift;
         tx_left <= next_tx_left;
         crc_en <= next_crc_en;
         blk_len <= next_blk_len;
         blk_set <= next_blk_set;
         tag_s <= next_tag_s;
         tag_e <= next_tag_e;
         erase_first <= next_erase_first;
         erase_last <= next_erase_last;
         wp_first <= next_wp_first;
         erase_start <= next_erase_start;
         lock_start <= next_lock_start;
         xfer_start <= next_xfer_start;
         xfer_write <= next_xfer_write;
         xfer_addr <= next_xfer_addr;
         data_len <= next_data_len;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         def_len <= next_def_len;
         rd_mis <= next_rd_mis;
         wr_mis <= next_wr_mis;
         opc <= next_opc;
         wp_last <= next_wp_last;
         reg_rdata <= next_reg_rdata;
      end
   end

   assign rsp_byte_o = rsp_byte;
   assign crc_check_en_o = crc_en;
   assign erase_start_o = erase_start;
   assign erase_first_o = erase_first;
   assign erase_last_o = erase_last;
   assign lock_start_o = lock_start;
   assign xfer_start_o = xfer_start;
   assign xfer_write_o = xfer_write;
   assign xfer_addr_o = xfer_addr;
   assign data_len_o = data_len;
   assign wp_first_o = wp_first;
   assign reg_rdata_o = reg_rdata;
   assign irq_o = |(irq_status & irq_mask);
endmodule : scs_cmd_core

/* test/scs_cmd_core_asserts.sv */
`timescale 1ns/10ps
module scs_cmd_core_asserts #(
   parameter int WP_SHIFT = 9
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic [5:0] cmd_index_i,
   input wire logic [31:0] cmd_arg_i,
   input wire logic cmd_crc_err_i,
   input wire logic rsp_valid_o,
   input wire logic [7:0] rsp_byte_o,
   input wire logic crc_check_en_o,
   input wire logic erase_start_o,
   input wire logic lock_start_o,
   input wire logic [31:0] wp_first_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic take;
   logic known;
   // a refused crc error executes nothing, so it is no take
   assign take = cmd_valid_i && !rsp_valid_o &&
      !(crc_check_en_o && cmd_crc_err_i);
   assign known = cmd_index_i inside {6'h10, 6'h11, 6'h18, 6'h1e,
      6'h23, 6'h24, 6'h26, 6'h2a, 6'h3a, 6'h3b};

   a_status_msb: assert property (
      $rose(rsp_valid_o) |-> rsp_byte_o[7] == 1'b0)
      else $error("status byte top bit set");
   a_answer_time: assert property (
      cmd_valid_i && !rsp_valid_o |-> ##1 rsp_valid_o)
      else $error("no status byte after command");
   a_crc_toggle: assert property (
      take && cmd_index_i == 6'h3b |=>
      crc_check_en_o == $past(cmd_arg_i[0]))
      else $error("crc enable not from argument bit 0");
   a_crc_stable: assert property (
      !(take && cmd_index_i == 6'h3b) |=> $stable(crc_check_en_o))
      else $error("crc enable moved without toggle command");
   a_illegal_flag: assert property (
      take && !known |=> rsp_byte_o[2])
      else $error("unsupported command not flagged");
   a_param_err: assert property (
      take && cmd_index_i == 6'h10 &&
      (cmd_arg_i == 0 || cmd_arg_i > 32'h0000_0800) |=> rsp_byte_o[6])
      else $error("bad block length not flagged");
   a_erase_cause: assert property (
      erase_start_o |-> $past(cmd_valid_i) && $past(cmd_index_i) == 6'h26)
      else $error("erase start without erase command");
   a_lock_cause: assert property (
      lock_start_o |-> $past(cmd_valid_i) && $past(cmd_index_i) == 6'h2a)
      else $error("lock start without lock command");
   a_wp_first: assert property (
      take && cmd_index_i == 6'h1e |=>
      wp_first_o == ($past(cmd_arg_i) >> WP_SHIFT))
      else $error("protect group start wrong");
endmodule : scs_cmd_core_asserts

bind scs_cmd_core scs_cmd_core_asserts #(.WP_SHIFT(WP_SHIFT)) chk_i (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
   .cmd_index_i(cmd_index_i), .cmd_arg_i(cmd_arg_i),
   .cmd_crc_err_i(cmd_crc_err_i), .rsp_valid_o(rsp_valid_o),
   .rsp_byte_o(rsp_byte_o), .crc_check_en_o(crc_check_en_o),
   .erase_start_o(erase_start_o), .lock_start_o(lock_start_o),
   .wp_first_o(wp_first_o));

/* test/scs_host_model.sv */
`timescale 1ns/10ps
module scs_host_model (
   input wire logic clk_i,
   input wire logic slow_i,
   output logic cmd_valid_o,
   output logic [5:0] cmd_index_o,
   output logic [31:0] cmd_arg_o,
   output logic cmd_crc_err_o,
   output logic rsp_ready_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_index_o = 6'h00;
      cmd_arg_o = 32'h0000_0000;
      cmd_crc_err_o = 1'b0;
      rsp_ready_o = 1'b1;
   end
   // a slow host refuses about one byte in four
   always @(posedge clk_i)
      rsp_ready_o <= !slow_i || $urandom_range(3) != 0;
   // caller guarantees the core is idle, so one cycle is enough
   task automatic issue(logic [5:0] i, logic [31:0] a, logic e);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_index_o <= i;
      cmd_arg_o <= a;
      cmd_crc_err_o <= e;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      // stale fields scrambled, nothing may lean on them
      cmd_index_o <= ~i;
      cmd_arg_o <= ~a;
      cmd_crc_err_o <= ~e;
   endtask : issue
endmodule : scs_host_model

/* test/tb_spi_card_command_subset.sv */
`timescale 1ns/10ps
module tb_spi_card_command_subset;
   logic clk, rst_n, cv, ce, idle, bb, rdy, rv, crc_en, es, ls, xs, xw;
   logic wr, rd, irq, slow, bsy_ok;
   logic [5:0] ci;
   logic [7:0] rb, ra;
   logic [11:0] dl;
   logic [31:0] ca, wpb, ef, el, xa, wf, wd, rdat;
   logic [7:0] exp_q[$];
   int fail_count, checks_done, n_x, n_e, n_l, cyc;

   scs_cmd_core uut (
      .core_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv),
      .cmd_index_i(ci), .cmd_arg_i(ca), .cmd_crc_err_i(ce),
      .card_idle_i(idle), .backend_busy_i(bb), .wp_bits_i(wpb),
      .rsp_ready_i(rdy), .rsp_valid_o(rv), .rsp_byte_o(rb),
      .crc_check_en_o(crc_en), .erase_start_o(es), .erase_first_o(ef),
      .erase_last_o(el), .lock_start_o(ls), .xfer_start_o(xs),
      .xfer_write_o(xw), .xfer_addr_o(xa), .data_len_o(dl),
      .wp_first_o(wf), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdat), .irq_o(irq));
   scs_host_model host (
      .clk_i(clk), .slow_i(slow), .cmd_valid_o(cv), .cmd_index_o(ci),
      .cmd_arg_o(ca), .cmd_crc_err_o(ce), .rsp_ready_o(rdy));

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
      checks_done++;
      if (seen !== ex) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic wreg(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wreg
   task automatic rreg(logic [7:0] a, logic [31:0] ex);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("register", rdat, ex);
   endtask : rreg
   task automatic cmd(logic [5:0] i, logic [31:0] a, logic e,
         logic [7:0] st, logic [7:0] m[$]);
      logic b;
      b = 1'($urandom_range(1));
      idle <= b;
      exp_q.push_back(st | {7'h00, b});
      foreach (m[k]) exp_q.push_back(m[k]);
      host.issue(i, a, e);
      repeat (300) begin
         @(posedge clk);
         #1;
         if (exp_q.size() == 0 && rv === 1'b0) break;
      end
      chk("response drained", exp_q.size(), 0);
   endtask : cmd
   // back end stays busy well past the status byte
   task automatic busy(logic [5:0] i);
      bsy_ok = 1'b1;
      bb <= 1'b1;
      fork
         cmd(i, $urandom, 1'b0, 8'h00, '{});
         begin
            repeat (20) @(posedge clk);
            bb <= 1'b0;
         end
      join
      bsy_ok = 1'b0;
   endtask : busy
   function automatic logic [15:0] crc16(logic [31:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int k = 31; k >= 0; k--)
         c = (c << 1) ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction : crc16

   always @(posedge clk) begin
      cyc++;
      if (es === 1'b1) n_e++;
      if (ls === 1'b1) n_l++;
      if (xs === 1'b1) n_x++;
      if (rst_n && rv === 1'b1 && rdy) begin
         if (exp_q.size() != 0)
            chk("response byte", rb, exp_q.pop_front());
         else if (bsy_ok)
            chk("busy byte", rb, 8'h00);
         else
            chk("extra byte", 1'b1, 1'b0);
      end
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      logic [31:0] w, r;
      logic [15:0] c;
      logic [5:0] bad[6];
      bad = '{6'h1f, 6'h27, 6'h28, 6'h29, 6'h2b, 6'h39};
      rst_n = 1'b0;
      {idle, bb, wr, rd, slow, bsy_ok} = 6'h00;
      {ra, wd, wpb} = 72'h0;
      void'($urandom(16));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rreg(8'h08, 32'h0000_0200);
      rreg(8'h0c, 32'h00ff_8000);
      rreg(8'h10, 32'hffff_ffff);
      rreg(8'h24, 32'h0000_0000);
      wreg(8'h04, 32'h0000_000f);
      slow <= 1'b1;
      wreg(8'h08, 32'h0000_0080);
      rreg(8'h14, 32'h0001_0080);
      cmd(6'h11, 32'h0000_0180, 1'b0, 8'h00, '{});
      chk("xfer addr", xa, 32'h0000_0180);
      cmd(6'h11, 32'h0000_0181, 1'b0, 8'h20, '{});
      wreg(8'h08, 32'h0000_3080);
      cmd(6'h11, 32'h0000_01f0, 1'b0, 8'h00, '{});
      cmd(6'h18, 32'h0000_01f0, 1'b0, 8'h00, '{});
      chk("xfer count", n_x, 3);
      chk("xfer write", xw, 1'b1);
      cmd(6'h3b, 32'hffff_fff1, 1'b0, 8'h00, '{});
      chk("crc on", crc_en, 1'b1);
      cmd(6'h3b, 32'h0000_0000, 1'b1, 8'h08, '{});
      chk("crc held", crc_en, 1'b1);
      cmd(6'h3b, 32'hffff_fffe, 1'b0, 8'h00, '{});
      chk("crc off", crc_en, 1'b0);
      foreach (bad[k]) cmd(bad[k], $urandom, 1'b0, 8'h04, '{});
      w = $urandom;
      wreg(8'h0c, w);
      cmd(6'h3a, 32'h0, 1'b0, 8'h00, '{w[31:24], w[23:16], w[15:8], w[7:0]});
      cmd(6'h10, 32'h0000_0000, 1'b0, 8'h40, '{});
      cmd(6'h10, 32'h0000_0801, 1'b0, 8'h40, '{});
      cmd(6'h10, 32'h0000_0100, 1'b0, 8'h00, '{});
      rreg(8'h14, 32'h0001_2100);
      cmd(6'h26, 32'h0, 1'b0, 8'h10, '{});
      cmd(6'h24, 32'h0000_0400, 1'b0, 8'h10, '{});
      cmd(6'h23, 32'h0000_0200, 1'b0, 8'h00, '{});
      cmd(6'h24, 32'h0000_0600, 1'b0, 8'h00, '{});
      busy(6'h26);
      chk("erase count", n_e, 1);
      chk("erase first", ef, 32'h0000_0200);
      chk("erase last", el, 32'h0000_0600);
      cmd(6'h23, 32'h0000_0200, 1'b0, 8'h00, '{});
      cmd(6'h3a, 32'h0, 1'b0, 8'h02, '{w[31:24], w[23:16], w[15:8], w[7:0]});
      cmd(6'h26, 32'h0, 1'b0, 8'h10, '{});
      chk("irq set", irq, 1'b1);
      rreg(8'h00, 32'h0000_000f);
      wreg(8'h00, 32'h0000_000f);
      rreg(8'h00, 32'h0000_0000);
      wreg(8'h04, 32'h0000_0002);
      cmd(6'h27, 32'h0, 1'b0, 8'h04, '{});
      chk("irq illegal", irq, 1'b1);
      wreg(8'h00, 32'h0000_0002);
      chk("irq masked", irq, 1'b0);
      wreg(8'h14, 32'h0000_0000);
      rreg(8'h14, 32'h0001_2100);
      busy(6'h2a);
      chk("lock count", n_l, 1);
      chk("lock length", dl, 12'h100);
      slow <= 1'b0;
      r = $urandom;
      wpb <= r;
      wreg(8'h10, 32'h0000_0055);
      w = r & 32'h0000_003f;
      c = crc16(w);
      cmd(6'h1e, 32'h0000_a000, 1'b0, 8'h00, '{8'hfe, w[31:24], w[23:16],
         w[15:8], w[7:0], c[15:8], c[7:0]});
      chk("wp first", wf, 32'h0000_0050);
      results();
   end
endmodule : tb_spi_card_command_subset
